/* File: adc_control_port.sv */
// two-wire control port slave and register bank of the converter
// assumes pins arrive raw; overflow pulses come from logic on clk
`timescale 1ns/1ns
`include "adc_ctrl_regs.svh"
module adc_control_port #(
   parameter logic [3:0] CHIP_IDENT = 4'h5, // arbitrary value
   parameter logic [3:0] CHIP_REVISION = 4'h0
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic addrStrapLsb,
   input wire logic addrStrapBit1,
   input wire logic pinClockRatio,
   input wire logic [1:0] pinDividerBits,
   input wire logic [1:0] pinSerialFormat,
   input wire logic [1:0] pinSpeedMode,
   input wire logic [7:0] chanOverflow,
   output logic overflowFlagOut,
   output logic overflowFlagOe,
   output logic portConfigEnable,
   output logic [3:0] divideTimesTwo,
   output logic divideReserved,
   output logic [1:0] serialFormatField,
   output logic clockMaster,
   output logic [1:0] speedSelect,
   output logic [7:0] dcFilterDisableBits,
   output logic [7:0] offsetFreeze,
   output logic [7:0] powerDownBits,
   output logic [7:0] silenceBits,
   output logic [7:0] outputDisableBits
);
   // ----------------------------------------
   // decoding function
   // ----------------------------------------
   // twice the divide ratio; zero marks the reserved code
   function automatic logic [3:0] div_x2(input logic [2:0] code);
      case (code)
         3'h0: div_x2 = 4'h2;
         3'h4: div_x2 = 4'h3;
         3'h1, 3'h2: div_x2 = 4'h4;
         3'h5, 3'h6: div_x2 = 4'h6;
         3'h3: div_x2 = 4'h8;
         default: div_x2 = 4'h0;
      endcase
   endfunction
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic sclS;
   logic sdaS;
   logic [6:0] cfgS;
   logic [1:0] strapS;
   pin_sync #(.WIDTH(2), .INIT(2'h3)) u_bus_sync (
      .clk(clk),
      .reset(reset),
      .pinIn({sclIn, sdaIn}),
      .pinOut({sclS, sdaS})
   );
   pin_sync #(.WIDTH(9), .INIT(9'h000)) u_cfg_sync (
      .clk(clk),
      .reset(reset),
      .pinIn({addrStrapBit1, addrStrapLsb, pinClockRatio, pinDividerBits,
              pinSerialFormat, pinSpeedMode}),
      .pinOut({strapS, cfgS})
   );
   // ----------------------------------------
   // strap capture
   // ----------------------------------------
   logic [2:0] strapWait_ff;
   logic [1:0] strap_ff;
   // waits out the synchroniser so the straps are those at the release
   always_ff @(posedge clk) begin
      if (reset) begin
         strapWait_ff <= 3'h0;
         strap_ff <= 2'h0;
      end else if (strapWait_ff != `STRAP_SETTLE) begin
         strapWait_ff <= strapWait_ff + 3'h1;
         strap_ff <= strapS;
      end
   end
   // ----------------------------------------
   // bus events
   // ----------------------------------------
   logic sclPrev_ff;
   logic sdaPrev_ff;
   always_ff @(posedge clk) begin
      if (reset) begin
         sclPrev_ff <= 1'b1;
         sdaPrev_ff <= 1'b1;
      end else begin
         sclPrev_ff <= sclS;
         sdaPrev_ff <= sdaS;
      end
   end
   wire sclRise = sclS & ~sclPrev_ff;
   wire sclFall = ~sclS & sclPrev_ff;
   wire startSeen = sclS & sclPrev_ff & sdaPrev_ff & ~sdaS;
   wire stopSeen = sclS & sclPrev_ff & ~sdaPrev_ff & sdaS;
   // ----------------------------------------
   // register bank
   // ----------------------------------------
   logic [7:0] global_ff;
   logic [7:0] mask_ff;
   logic [7:0] dcFilter_ff;
   logic [7:0] powerDown_ff;
   logic [7:0] silence_ff;
   logic [7:0] outEnable_ff;
   logic [7:0] ovfStatus;
   logic [6:0] ptr_ff;
   logic incr_ff;
   logic [7:0] readData;
   always_comb begin
      case (ptr_ff)
         `ADR_IDENTITY: readData = {CHIP_IDENT, CHIP_REVISION};
         `ADR_GLOBAL: readData = global_ff;
         `ADR_OVF_STATUS: readData = ovfStatus;
         `ADR_OVF_MASK: readData = mask_ff;
         `ADR_DC_FILTER: readData = dcFilter_ff;
         `ADR_POWER_DOWN: readData = powerDown_ff;
         `ADR_SILENCE: readData = silence_ff;
         `ADR_OUT_ENABLE: readData = outEnable_ff;
         default: readData = 8'h00;
      endcase
   end
   // ----------------------------------------
   // byte engine
   // ----------------------------------------
   adc_ctrl_pkg::port_state_t state_ff;
   logic [3:0] bitCnt_ff;
   logic [7:0] shift_ff;
   logic sdaOe_ff;
   logic [7:0] writeData;
   wire byteDone = sclFall & (bitCnt_ff == `BITS_PER_BYTE);
   wire addrMatch = shift_ff[7:1] == {`BUS_ADDR_FIXED, strap_ff};
   assign writeData = shift_ff;
   // a fall never meets start or stop, both need the clock high
   wire writeStrobe = byteDone & (state_ff == adc_ctrl_pkg::ST_WDATA);
   wire loadRead = sclFall & ((state_ff == adc_ctrl_pkg::ST_ADDR_ACK & shift_ff[0])
      | (state_ff == adc_ctrl_pkg::ST_RDATA_ACK));
   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= adc_ctrl_pkg::ST_IDLE;
         bitCnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         sdaOe_ff <= 1'b0;
         ptr_ff <= 7'h00;
         incr_ff <= 1'b0;
      end else if (startSeen) begin
         state_ff <= adc_ctrl_pkg::ST_ADDR;
         bitCnt_ff <= 4'h0;
         sdaOe_ff <= 1'b0;
      end else if (stopSeen) begin
         state_ff <= adc_ctrl_pkg::ST_IDLE;
         sdaOe_ff <= 1'b0;
      end else begin
         case (state_ff)
            adc_ctrl_pkg::ST_ADDR, adc_ctrl_pkg::ST_PTR, adc_ctrl_pkg::ST_WDATA: begin
               if (sclRise) begin
                  shift_ff <= {shift_ff[6:0], sdaS};
                  bitCnt_ff <= bitCnt_ff + 4'h1;
               end else if (byteDone) begin
                  sdaOe_ff <= 1'b1;
                  if (state_ff == adc_ctrl_pkg::ST_ADDR) begin
                     if (addrMatch) begin
                        state_ff <= adc_ctrl_pkg::ST_ADDR_ACK;
                     end else begin
                        sdaOe_ff <= 1'b0;
                        state_ff <= adc_ctrl_pkg::ST_IDLE;
                     end
                  end else if (state_ff == adc_ctrl_pkg::ST_PTR) begin
                     ptr_ff <= shift_ff[6:0];
                     incr_ff <= shift_ff[`PTR_INCR_BIT];
                     state_ff <= adc_ctrl_pkg::ST_PTR_ACK;
                  end else begin
                     ptr_ff <= incr_ff ? ptr_ff + 7'h01 : ptr_ff;
                     state_ff <= adc_ctrl_pkg::ST_WDATA_ACK;
                  end
               end
            end
            adc_ctrl_pkg::ST_ADDR_ACK, adc_ctrl_pkg::ST_PTR_ACK,
            adc_ctrl_pkg::ST_WDATA_ACK: begin
               if (sclFall) begin
                  bitCnt_ff <= 4'h0;
                  sdaOe_ff <= 1'b0;
                  if (loadRead) begin
                     // read data pre-shifted: bit 7 goes out now
                     shift_ff <= {readData[6:0], 1'b0};
                     sdaOe_ff <= ~readData[7];
                     ptr_ff <= incr_ff ? ptr_ff + 7'h01 : ptr_ff;
                     state_ff <= adc_ctrl_pkg::ST_RDATA;
                  end else if (state_ff == adc_ctrl_pkg::ST_ADDR_ACK) begin
                     state_ff <= adc_ctrl_pkg::ST_PTR;
                  end else begin
                     state_ff <= adc_ctrl_pkg::ST_WDATA;
                  end
               end
            end
            adc_ctrl_pkg::ST_RDATA: begin
               if (sclRise) begin
                  bitCnt_ff <= bitCnt_ff + 4'h1;
               end else if (byteDone) begin
                  sdaOe_ff <= 1'b0;
                  state_ff <= adc_ctrl_pkg::ST_RDATA_ACK;
               end else if (sclFall) begin
                  sdaOe_ff <= ~shift_ff[7];
                  shift_ff <= {shift_ff[6:0], 1'b0};
               end
            end
            adc_ctrl_pkg::ST_RDATA_ACK: begin
               // master's not-acknowledge ends the read
               if (sclRise && sdaS) begin
                  state_ff <= adc_ctrl_pkg::ST_IDLE;
               end else if (loadRead) begin
                  bitCnt_ff <= 4'h0;
                  shift_ff <= {readData[6:0], 1'b0};
                  sdaOe_ff <= ~readData[7];
                  ptr_ff <= incr_ff ? ptr_ff + 7'h01 : ptr_ff;
                  state_ff <= adc_ctrl_pkg::ST_RDATA;
               end
            end
            default: begin
               sdaOe_ff <= 1'b0;
               state_ff <= adc_ctrl_pkg::ST_IDLE;
            end
         endcase
      end
   end
   // ----------------------------------------
   // register writes
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         global_ff <= `RST_GLOBAL;
         mask_ff <= `RST_OVF_MASK;
         dcFilter_ff <= `RST_DC_FILTER;
         powerDown_ff <= `RST_POWER_DOWN;
         silence_ff <= `RST_SILENCE;
         outEnable_ff <= `RST_OUT_ENABLE;
      end else if (writeStrobe) begin
         case (ptr_ff)
            `ADR_GLOBAL: global_ff <= writeData;
            `ADR_OVF_MASK: mask_ff <= writeData;
            `ADR_DC_FILTER: dcFilter_ff <= writeData;
            `ADR_POWER_DOWN: powerDown_ff <= writeData & `MASK_POWER_DOWN;
            `ADR_SILENCE: silence_ff <= writeData;
            `ADR_OUT_ENABLE: outEnable_ff <= writeData & `MASK_OUT_ENABLE;
            default: global_ff <= global_ff;
         endcase
      end
   end
   // ----------------------------------------
   // overflow status
   // ----------------------------------------
   wire statusRead = loadRead & (ptr_ff == `ADR_OVF_STATUS);
   overflow_status #(.CHANNELS(8)) u_ovf (
      .clk(clk),
      .reset(reset),
      .chanOverflow(chanOverflow),
      .maskBits(mask_ff),
      .readRestore(statusRead),
      .statusBits(ovfStatus),
      .flagOe(overflowFlagOe)
   );
   // ----------------------------------------
   // configuration outputs
   // ----------------------------------------
   wire cfgEn = global_ff[`GC_ENABLE_BIT];
   // pins are ignored once software takes over
   wire [6:0] cfgSel = cfgEn ? global_ff[`GC_RATIO_BIT:0] : cfgS;
   logic [3:0] divX2_ff;
   logic divRsvd_ff;
   logic cfgEn_ff;
   logic master_ff;
   logic [1:0] fmt_ff;
   logic [1:0] speed_ff;
   logic [7:0] hpf_ff;
   // enable is registered with the fields so all of them switch together
   always_ff @(posedge clk) begin
      if (reset) begin
         divX2_ff <= 4'h2;
         divRsvd_ff <= 1'b0;
         cfgEn_ff <= 1'b0;
         master_ff <= 1'b1;
         fmt_ff <= 2'h0;
         speed_ff <= 2'h0;
         hpf_ff <= `RST_DC_FILTER;
      end else begin
         divX2_ff <= div_x2(cfgSel[`GC_RATIO_BIT:`GC_DIV_LO]);
         divRsvd_ff <= div_x2(cfgSel[`GC_RATIO_BIT:`GC_DIV_LO]) == 4'h0;
         cfgEn_ff <= cfgEn;
         master_ff <= cfgSel[`GC_SPEED_HI:`GC_SPEED_LO] != 2'h3;
         fmt_ff <= cfgSel[`GC_FMT_HI:`GC_FMT_LO];
         speed_ff <= cfgSel[`GC_SPEED_HI:`GC_SPEED_LO];
         // stand-alone keeps every filter running
         hpf_ff <= cfgEn ? dcFilter_ff : `RST_DC_FILTER;
      end
   end
   assign sdaOut = 1'b0;
   assign sdaOe = sdaOe_ff;
   assign overflowFlagOut = 1'b0;
   assign portConfigEnable = cfgEn_ff;
   assign divideTimesTwo = divX2_ff;
   assign divideReserved = divRsvd_ff;
   assign serialFormatField = fmt_ff;
   assign clockMaster = master_ff;
   assign speedSelect = speed_ff;
   assign dcFilterDisableBits = hpf_ff;
   assign offsetFreeze = hpf_ff;
   assign powerDownBits = powerDown_ff;
   assign silenceBits = silence_ff;
   assign outputDisableBits = outEnable_ff;
endmodule

/* File: adc_ctrl_regs.svh */
// register offsets, field positions and reset values of the control port
// assumes inclusion by bare name from each design file that uses it
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADR_IDENTITY 7'h00
`define ADR_GLOBAL 7'h01
`define ADR_OVF_STATUS 7'h02
`define ADR_OVF_MASK 7'h03
`define ADR_DC_FILTER 7'h04
`define ADR_POWER_DOWN 7'h06
`define ADR_SILENCE 7'h08
`define ADR_OUT_ENABLE 7'h0a

// ----------------------------------------
// reset values and writable bits
// ----------------------------------------
`define RST_GLOBAL 8'h00
`define RST_OVF_STATUS 8'hff
`define RST_OVF_MASK 8'hff
`define RST_DC_FILTER 8'h00
`define RST_POWER_DOWN 8'h00
`define RST_SILENCE 8'h00
`define RST_OUT_ENABLE 8'h00
`define MASK_POWER_DOWN 8'h3f
`define MASK_OUT_ENABLE 8'h0f

// ----------------------------------------
// global control fields
// ----------------------------------------
`define GC_ENABLE_BIT 7
`define GC_RATIO_BIT 6
`define GC_DIV_HI 5
`define GC_DIV_LO 4
`define GC_FMT_HI 3
`define GC_FMT_LO 2
`define GC_SPEED_HI 1
`define GC_SPEED_LO 0

// ----------------------------------------
// bus address and pointer byte
// ----------------------------------------
`define BUS_ADDR_FIXED 5'h13
`define PTR_INCR_BIT 7
`define BITS_PER_BYTE 4'h8
`define STRAP_SETTLE 3'h5

`endif

/* File: adc_ctrl_pkg.sv */
// types shared by the control port files
// assumes nothing beyond a SystemVerilog compiler
package adc_ctrl_pkg;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_ADDR = 4'h1,
      ST_ADDR_ACK = 4'h2,
      ST_PTR = 4'h3,
      ST_PTR_ACK = 4'h4,
      ST_WDATA = 4'h5,
      ST_WDATA_ACK = 4'h6,
      ST_RDATA = 4'h7,
      ST_RDATA_ACK = 4'h8
   } port_state_t;

   typedef enum logic [1:0] {
      FMT_LEFT = 2'h0,
      FMT_I2S = 2'h1,
      FMT_TDM = 2'h2,
      FMT_RSVD = 2'h3
   } serial_format_t;

endpackage

/* File: pin_sync.sv */
// three-flop synchroniser with agreement filter for pin inputs
// assumes asynchronous pins, single clk domain
`timescale 1ns/1ns
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] pinOut
);
   initial begin
      if (WIDTH < 1) $error("pin_sync width must be positive");
   end

   logic [WIDTH-1:0] stage1_ff;
   logic [WIDTH-1:0] stage2_ff;
   logic [WIDTH-1:0] stage3_ff;
   logic [WIDTH-1:0] filt_ff;

   // ----------------------------------------
   // per-bit chain
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always_ff @(posedge clk) begin
            if (reset) begin
               stage1_ff[i] <= INIT[i];
               stage2_ff[i] <= INIT[i];
               stage3_ff[i] <= INIT[i];
               filt_ff[i] <= INIT[i];
            end else begin
               stage1_ff[i] <= pinIn[i];
               stage2_ff[i] <= stage1_ff[i];
               stage3_ff[i] <= stage2_ff[i];
               // stage1 only feeds stage2; glitches need two agreeing samples
               if (stage2_ff[i] == stage3_ff[i]) begin
                  filt_ff[i] <= stage3_ff[i];
               end
            end
         end
      end
   endgenerate

   assign pinOut = filt_ff;
endmodule

/* File: overflow_status.sv */
// sticky active-low overflow status and masked open-drain flag
// assumes overflow pulses come from logic on clk
`timescale 1ns/1ns
`include "adc_ctrl_regs.svh"
module overflow_status #(
   parameter int CHANNELS = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [CHANNELS-1:0] chanOverflow,
   input wire logic [CHANNELS-1:0] maskBits,
   input wire logic readRestore,
   output logic [CHANNELS-1:0] statusBits,
   output logic flagOe
);
   initial begin
      if (CHANNELS != 8) $error("overflow_status serves eight channels");
   end

   logic [CHANNELS-1:0] status_ff;
   logic flagOe_ff;
   wire [CHANNELS-1:0] nxt_status;
   wire nxt_flagOe;

   // ----------------------------------------
   // status and flag
   // ----------------------------------------
   // a new overflow beats the read restore so no event is lost
   assign nxt_status = (readRestore ? {CHANNELS{1'b1}} : status_ff) & ~chanOverflow;
   // mask low blocks the channel from pulling the flag
   assign nxt_flagOe = |(~nxt_status & maskBits);

   always_ff @(posedge clk) begin
      if (reset) begin
         status_ff <= `RST_OVF_STATUS;
         flagOe_ff <= 1'b0;
      end else begin
         status_ff <= nxt_status;
         flagOe_ff <= nxt_flagOe;
      end
   end

   assign statusBits = status_ff;
   assign flagOe = flagOe_ff;
endmodule

/* File: adc_control_port_properties.sv */
// concurrent checks on the control port's pins and configuration outputs
// assumes binding onto adc_control_port, one clock, synchronous reset
`timescale 1ns/1ns
module adc_control_port_properties (
   input wire logic clk,
   input wire logic reset,
   input wire logic sclIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic overflowFlagOut,
   input wire logic overflowFlagOe,
   input wire logic portConfigEnable,
   input wire logic [3:0] divideTimesTwo,
   input wire logic divideReserved,
   input wire logic clockMaster,
   input wire logic [1:0] speedSelect,
   input wire logic [7:0] dcFilterDisableBits,
   input wire logic [7:0] offsetFreeze
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   chk_reset_outputs: assert property (
      $fell(reset) |-> !sdaOe && !overflowFlagOe && !portConfigEnable
      && dcFilterDisableBits == 8'h00)
      else $error("outputs not at reset values");
   chk_open_drain: assert property (
      sdaOut == 1'b0 && overflowFlagOut == 1'b0)
      else $error("open drain pin drives high");
   chk_master_role: assert property (
      clockMaster == (speedSelect != 2'h3))
      else $error("clock role disagrees with speed code");
   chk_divide_rsvd: assert property (
      divideReserved == (divideTimesTwo == 4'h0))
      else $error("reserved divider flag wrong");
   chk_filter_gate: assert property (
      !portConfigEnable |-> dcFilterDisableBits == 8'h00)
      else $error("filter disabled while stand-alone");
   chk_freeze_tie: assert property (
      offsetFreeze == dcFilterDisableBits)
      else $error("offset freeze differs from filter bits");
   // a late answer would change data while the bus clock is high
   chk_drive_low_scl: assert property (
      $rose(sdaOe) |-> !$past(sclIn, 3))
      else $error("data driven outside clock low");
   chk_stable_high: assert property (
      sclIn [*8] ##1 sclIn |-> $stable(sdaOe))
      else $error("data changed while clock high");
endmodule

bind adc_control_port adc_control_port_properties i_adc_control_port_properties (
   .clk, .reset, .sclIn, .sdaOut, .sdaOe, .overflowFlagOut, .overflowFlagOe,
   .portConfigEnable, .divideTimesTwo, .divideReserved, .clockMaster, .speedSelect,
   .dcFilterDisableBits, .offsetFreeze
);

/* File: i2c_host_model.sv */
// two-wire bus master model: start, stop, byte write and byte read
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ns
module i2c_host_model (
   input wire logic clk,
   input wire logic sdaLine,
   output logic scl,
   output logic sdaLow
);
   // ----------------------------------------
   // bus phases
   // ----------------------------------------
   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end
   // eleven cycles a phase, above the 8-cycle minimum level time
   task automatic setBus(input logic s, input logic d);
      @(posedge clk);
      scl <= s;
      sdaLow <= d;
      repeat (10) @(posedge clk);
   endtask
   task automatic start();
      setBus(1'b0, 1'b0);
      setBus(1'b1, 1'b0);
      setBus(1'b1, 1'b1);
      setBus(1'b0, 1'b1);
   endtask
   task automatic stop();
      setBus(1'b0, 1'b1);
      setBus(1'b1, 1'b1);
      setBus(1'b1, 1'b0);
   endtask
   // data moves only with clock low, sampled at end of high phase
   task automatic bitCycle(input logic b, output logic r);
      setBus(1'b0, !b);
      setBus(1'b1, !b);
      r = sdaLine;
      setBus(1'b0, !b);
   endtask
   task automatic wrByte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitCycle(d[i], r);
      bitCycle(1'b1, r);
      ack = !r;
   endtask
   task automatic rdByte(input logic mAck, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bitCycle(1'b1, d[i]);
      bitCycle(!mAck, r);
   endtask
endmodule

/* File: adc_control_port_i2c_regs_test.sv */
// self-checking bench for the converter control port and register bank
// assumes the host model owns the bus clock; data wire has a pull-up
`timescale 1ns/1ns
module adc_control_port_i2c_regs_test;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic addrStrapLsb = 1'b0;
   logic addrStrapBit1 = 1'b1;
   logic pinClockRatio = 1'b1;
   logic [1:0] pinDividerBits = 2'h1;
   logic [1:0] pinSerialFormat = 2'h2;
   logic [1:0] pinSpeedMode = 2'h3;
   logic [7:0] chanOverflow = 8'h00;
   logic scl, sdaLow, sdaOut, sdaOe, overflowFlagOut, overflowFlagOe, portConfigEnable;
   logic divideReserved, clockMaster, ack;
   logic [3:0] divideTimesTwo;
   logic [1:0] serialFormatField, speedSelect;
   logic [7:0] dcFilterDisableBits, offsetFreeze, powerDownBits, silenceBits, outputDisableBits;
   logic [6:0] devAddr = 7'h4e;
   logic [7:0] txq [$];
   logic [7:0] expq [$];
   logic [3:0] divTab [8] = '{4'h2, 4'h4, 4'h4, 4'h8, 4'h3, 4'h6, 4'h6, 4'h0};
   int mismatches = 0;
   int comparisons = 0;
   wire logic sdaLine = !(sdaLow || (sdaOe && !sdaOut));
   always #4 clk = !clk;
   // identity nibble is arbitrary
   adc_control_port #(.CHIP_IDENT(4'h5), .CHIP_REVISION(4'h1)) i_adc_control_port (
      .clk, .reset, .sclIn(scl), .sdaIn(sdaLine), .sdaOut, .sdaOe, .addrStrapLsb,
      .addrStrapBit1, .pinClockRatio, .pinDividerBits, .pinSerialFormat, .pinSpeedMode,
      .chanOverflow, .overflowFlagOut, .overflowFlagOe, .portConfigEnable, .divideTimesTwo,
      .divideReserved, .serialFormatField, .clockMaster, .speedSelect, .dcFilterDisableBits,
      .offsetFreeze, .powerDownBits, .silenceBits, .outputDisableBits
   );
   i2c_host_model i_i2c_host_model (.clk, .sdaLine, .scl, .sdaLow);
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic addrByte(input logic rd);
      i_i2c_host_model.start();
      i_i2c_host_model.wrByte({devAddr, rd}, ack);
      cmp8({7'h0, ack}, 8'h01);
   endtask
   task automatic dataByte(input logic [7:0] d);
      i_i2c_host_model.wrByte(d, ack);
      cmp8({7'h0, ack}, 8'h01);
   endtask
   task automatic wrRegs(input logic [7:0] ptr);
      addrByte(1'b0);
      dataByte(ptr);
      foreach (txq[i]) dataByte(txq[i]);
      i_i2c_host_model.stop();
   endtask
   task automatic rdRegs(input logic [7:0] ptr);
      logic [7:0] b;
      addrByte(1'b0);
      dataByte(ptr);
      i_i2c_host_model.stop();
      addrByte(1'b1);
      foreach (expq[i]) begin
         i_i2c_host_model.rdByte(i != expq.size() - 1, b);
         cmp8(b, expq[i]);
      end
      i_i2c_host_model.stop();
   endtask
   task automatic nackProbe(input logic [6:0] a);
      i_i2c_host_model.start();
      i_i2c_host_model.wrByte({a, 1'b0}, ack);
      cmp8({7'h0, ack}, 8'h00);
      i_i2c_host_model.wrByte(8'h01, ack);
      cmp8({7'h0, ack}, 8'h00);
      i_i2c_host_model.stop();
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic testResetValues();
      cmp8({4'h0, divideTimesTwo}, 8'h06);
      cmp8({6'h0, serialFormatField}, 8'h02);
      cmp8({6'h0, speedSelect}, 8'h03);
      expq = {8'h51, 8'h00, 8'hff, 8'hff, 8'h00};
      rdRegs(8'h80);
      $display("reset values test done");
   endtask
   task automatic testPointer();
      txq = {8'h0f, 8'ha5};
      wrRegs(8'h83);
      expq = {8'h0f, 8'h0f};
      rdRegs(8'h03);
      expq = {8'ha5};
      rdRegs(8'h04);
      cmp8(dcFilterDisableBits, 8'h00);
      $display("pointer test done");
   endtask
   task automatic testGlobal();
      @(posedge clk);
      pinClockRatio <= 1'b0;
      pinSerialFormat <= 2'h0;
      for (int i = 0; i < 8; i++) begin
         txq = {{1'b1, 3'(i), 2'(i), 2'(i + 1)}};
         wrRegs(8'h01);
         cmp8({4'h0, divideTimesTwo}, {4'h0, divTab[i]});
         cmp8({7'h0, divideReserved}, {7'h0, i == 7});
         cmp8({6'h0, serialFormatField}, {6'h0, 2'(i)});
         cmp8({6'h0, speedSelect}, {6'h0, 2'(i + 1)});
         cmp8({7'h0, clockMaster}, {7'h0, 2'(i + 1) != 2'h3});
      end
      cmp8({7'h0, portConfigEnable}, 8'h01);
      cmp8(dcFilterDisableBits, 8'ha5);
      cmp8(offsetFreeze, 8'ha5);
      expq = {8'hfc};
      rdRegs(8'h01);
      $display("global control test done");
   endtask
   task automatic testReserved();
      txq = {8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
      wrRegs(8'h85);
      expq = {8'h00, 8'h3f, 8'h00, 8'hff, 8'h00, 8'h0f, 8'h00};
      rdRegs(8'h85);
      cmp8(powerDownBits, 8'h3f);
      cmp8(silenceBits, 8'hff);
      cmp8(outputDisableBits, 8'h0f);
      $display("reserved test done");
   endtask
   // mask is 0fh here, so channel 8 must stay silent on the flag
   task automatic testOverflow();
      @(posedge clk) chanOverflow <= 8'h80;
      @(posedge clk) chanOverflow <= 8'h00;
      repeat (4) @(posedge clk);
      cmp8({7'h0, overflowFlagOe}, 8'h00);
      chanOverflow <= 8'h01;
      @(posedge clk) chanOverflow <= 8'h00;
      repeat (4) @(posedge clk);
      cmp8({7'h0, overflowFlagOe}, 8'h01);
      expq = {8'h7e};
      rdRegs(8'h02);
      cmp8({7'h0, overflowFlagOe}, 8'h00);
      expq = {8'hff};
      rdRegs(8'h02);
      $display("overflow test done");
   endtask
   task automatic testAddress();
      nackProbe(7'h4f);
      nackProbe(7'h0e);
      @(posedge clk) addrStrapLsb <= 1'b1;
      addrStrapBit1 <= 1'b0;
      nackProbe(7'h4d);
      expq = {8'h0f};
      rdRegs(8'h03);
      $display("address test done");
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      repeat (10) @(posedge clk);
      testResetValues();
      testPointer();
      testGlobal();
      testReserved();
      testOverflow();
      testAddress();
      end_of_test();
   end
   // about three times the expected run length
   initial begin
      repeat (90000) @(posedge clk);
      mismatches++;
      end_of_test();
   end
endmodule
